// ===== logic/usb_glue_pkg.sv
// Shared constants and types for the three-core routing and interrupt glue
package usb_glue_pkg;

  localparam int NUM_CORES = 3;
  localparam int NUM_PORTS = 5;
  localparam int DATA_W = 32;
  localparam int LANE_W = 8;

  // Core indices on every per-core vector
  localparam int CORE_FS1 = 0;
  localparam int CORE_FS2 = 1;
  localparam int CORE_HS = 2;

  // Ports each core may ever serve, bit 0 is downstream port one
  localparam logic [4:0] FS1_PORT_MASK = 5'h15;
  localparam logic [4:0] FS2_PORT_MASK = 5'h0A;
  localparam logic [4:0] HS_PORT_MASK = 5'h1F;

  // Enabled port count limits and reset value
  localparam logic [2:0] PORT_COUNT_MIN = 3'h2;
  localparam logic [2:0] PORT_COUNT_MAX = 3'h5;
  localparam logic [2:0] PORT_COUNT_RST = 3'h5;

  // Target space code and the highest function number that exists
  localparam logic TGT_SPACE_MEM = 1'h1;
  localparam logic [1:0] TGT_FUNC_LAST = 2'h2;

  // Which core owns a downstream port
  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_FS1 = 2'b01,
    OWN_FS2 = 2'b10,
    OWN_HS = 2'b11
  } owner_t;

  // Master-side arbiter states
  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_t;

endpackage

// ===== logic/master_arbiter.sv
// Round-robin arbiter handing the shared bus master to one core at a time
`timescale 1ns/1ps
module master_arbiter
  import usb_glue_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] req,
  input wire logic done,
  output logic [2:0] grant
);

  arb_state_t state_q, state_d;
  logic [2:0] grant_q, grant_d;
  logic [2:0] last_q, last_d;

  // Pick next requester after the last winner so no core starves
  function automatic logic [2:0] rr_pick(input logic [2:0] r, input logic [2:0] last);
    logic [2:0] pick;
    pick = 3'h0;
    if (last[0])
      pick = r[1] ? 3'h2 : (r[2] ? 3'h4 : (r[0] ? 3'h1 : 3'h0));
    else if (last[1])
      pick = r[2] ? 3'h4 : (r[0] ? 3'h1 : (r[1] ? 3'h2 : 3'h0));
    else
      pick = r[0] ? 3'h1 : (r[1] ? 3'h2 : (r[2] ? 3'h4 : 3'h0));
    return pick;
  endfunction

  // Grant is one-hot and held until the granted transfer completes
  always_comb
  begin
    state_d = state_q;
    grant_d = grant_q;
    last_d = last_q;
    unique case (state_q)
      ARB_IDLE:
      begin
        if (|req)
        begin
          grant_d = rr_pick(req, last_q);
          last_d = rr_pick(req, last_q);
          state_d = ARB_BUSY;
        end
      end
      ARB_BUSY:
      begin
        if (done)
        begin
          grant_d = 3'h0;
          state_d = ARB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ARB_IDLE;
      grant_q <= 3'h0;
      last_q <= 3'h4;
    end
    else
    begin
      state_q <= state_d;
      grant_q <= grant_d;
      last_q <= last_d;
    end
  end

  assign grant = grant_q;

endmodule

// ===== logic/usb_core_port_routing_irq_merge.sv
// Bus arbitration, root-hub port routing and interrupt merging for three host cores
//
// Behaviour
// - Bus-master access is granted to one of the three cores at a time, round robin.
// - The first full/low-speed core reaches only ports one, three and five.
// - The second full/low-speed core reaches only ports two and four.
// - The high-speed core may reach all five ports.
// - The root hub decides per port which core is connected to it.
// - Every port carries any speed, the hub choosing the high-speed or companion core.
// - The first interrupt line follows the first full/low-speed core's request.
// - The second interrupt line follows the second full/low-speed core's request.
// - The third interrupt line follows the high-speed core's request.
// - A sharing option folds the second and third requests onto the first line.
// - The management interrupts of all cores merge onto one output.
// - The wake requests of all cores merge onto the power-event output.
// - The enabled port count comes from configuration, limited to two through five.
// - The host side is a 32-bit master and target path.
// - Core registers are claimed only for memory-space target accesses.
`timescale 1ns/1ps
module usb_core_port_routing_irq_merge
  import usb_glue_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // Configuration straps and settings
  input wire logic [2:0] port_count_cfg,
  input wire logic irq_share_cfg,
  // Core master requests, one word per core
  input wire logic [2:0] core_mreq,
  input wire logic [2:0] core_mwrite,
  input wire logic [95:0] core_maddr,
  input wire logic [95:0] core_mwdata,
  output logic [2:0] core_mack,
  output logic [31:0] core_mrdata,
  // Shared host bus master engine
  output logic mst_req,
  output logic mst_write,
  output logic [31:0] mst_addr,
  output logic [31:0] mst_wdata,
  input wire logic mst_done,
  input wire logic [31:0] mst_rdata,
  // Host bus target decode side
  input wire logic tgt_valid,
  input wire logic tgt_space,
  input wire logic [1:0] tgt_func,
  input wire logic tgt_write,
  input wire logic [31:0] tgt_addr,
  input wire logic [31:0] tgt_wdata,
  output logic tgt_claim,
  output logic tgt_reject,
  output logic tgt_done,
  output logic [31:0] tgt_rdata,
  // Core target side
  output logic [2:0] core_tsel,
  output logic core_twrite,
  output logic [31:0] core_taddr,
  output logic [31:0] core_twdata,
  input wire logic [2:0] core_tack,
  input wire logic [95:0] core_trdata,
  // Root hub ownership
  input wire logic [4:0] hs_port_claim,
  output logic [9:0] port_owner,
  output logic [4:0] port_enabled,
  // Per-core per-port line traffic, byte per port
  input wire logic [14:0] core_tx_en,
  input wire logic [119:0] core_tx_data,
  output logic [14:0] core_rx_valid,
  output logic [39:0] core_rx_data,
  // Transceiver side
  output logic [4:0] phy_tx_en,
  output logic [39:0] phy_tx_data,
  input wire logic [4:0] phy_rx_valid,
  input wire logic [39:0] phy_rx_data,
  // Interrupts and wake
  input wire logic [2:0] core_irq,
  input wire logic [2:0] core_smi,
  input wire logic [2:0] core_wake,
  output logic int_a_oe,
  output logic int_b_oe,
  output logic int_c_oe,
  output logic sys_mgmt_irq_out_n,
  output logic pme_oe
);

  // Ports a core is allowed to drive, used by ownership and gating
  function automatic logic [4:0] core_mask(input owner_t own);
    logic [4:0] m;
    m = 5'h00;
    unique case (own)
      OWN_FS1: m = FS1_PORT_MASK;
      OWN_FS2: m = FS2_PORT_MASK;
      OWN_HS: m = HS_PORT_MASK;
      OWN_NONE: m = 5'h00;
    endcase
    return m;
  endfunction

  // Companion core wired to a port when the high-speed core does not hold it
  function automatic owner_t companion(input int p);
    owner_t own;
    logic [4:0] fs1_m;
    logic [4:0] fs2_m;
    own = OWN_NONE;
    fs1_m = core_mask(OWN_FS1);
    fs2_m = core_mask(OWN_FS2);
    if (fs1_m[p])
      own = OWN_FS1;
    else if (fs2_m[p])
      own = OWN_FS2;
    return own;
  endfunction

  // ---------------- Configuration ----------------
  logic [2:0] port_count_q, port_count_d;

  // Out-of-range settings clamp so the port count never leaves 2..5
  always_comb
  begin
    port_count_d = port_count_cfg;
    if (port_count_cfg < PORT_COUNT_MIN)
      port_count_d = PORT_COUNT_MIN;
    else if (port_count_cfg > PORT_COUNT_MAX)
      port_count_d = PORT_COUNT_MAX;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_count_q <= PORT_COUNT_RST;
    end
    else
    begin
      port_count_q <= port_count_d;
    end
  end

  // ---------------- Master path ----------------
  logic [2:0] grant;
  logic [1:0] gidx;
  logic mst_req_q, mst_req_d;
  logic mst_write_q, mst_write_d;
  logic [31:0] mst_addr_q, mst_addr_d;
  logic [31:0] mst_wdata_q, mst_wdata_d;
  logic [2:0] core_mack_q, core_mack_d;
  logic [31:0] core_mrdata_q, core_mrdata_d;

  master_arbiter u_arb (
    .clk(clk),
    .rstn(rstn),
    .req(core_mreq),
    .done(mst_done & mst_req_q),
    .grant(grant)
  );

  assign gidx = grant[2] ? 2'h2 : (grant[1] ? 2'h1 : 2'h0);

  // Launch the winner's cycle once, then hand the answer back to it alone
  always_comb
  begin
    mst_req_d = mst_req_q;
    mst_write_d = mst_write_q;
    mst_addr_d = mst_addr_q;
    mst_wdata_d = mst_wdata_q;
    core_mack_d = 3'h0;
    core_mrdata_d = core_mrdata_q;
    if (mst_req_q && mst_done)
    begin
      mst_req_d = 1'h0;
      core_mack_d = grant;
      core_mrdata_d = mst_rdata;
    end
    else if (!mst_req_q && (|grant) && !(|core_mack_q))
    begin
      mst_req_d = 1'h1;
      mst_write_d = core_mwrite[gidx];
      mst_addr_d = core_maddr[gidx * DATA_W +: DATA_W];
      mst_wdata_d = core_mwdata[gidx * DATA_W +: DATA_W];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mst_req_q <= 1'h0;
      mst_write_q <= 1'h0;
      mst_addr_q <= 32'h0;
      mst_wdata_q <= 32'h0;
      core_mack_q <= 3'h0;
      core_mrdata_q <= 32'h0;
    end
    else
    begin
      mst_req_q <= mst_req_d;
      mst_write_q <= mst_write_d;
      mst_addr_q <= mst_addr_d;
      mst_wdata_q <= mst_wdata_d;
      core_mack_q <= core_mack_d;
      core_mrdata_q <= core_mrdata_d;
    end
  end

  // ---------------- Target path ----------------
  logic tgt_claim_q, tgt_claim_d;
  logic tgt_reject_q, tgt_reject_d;
  logic tgt_done_q, tgt_done_d;
  logic [31:0] tgt_rdata_q, tgt_rdata_d;
  logic [2:0] core_tsel_q, core_tsel_d;
  logic core_twrite_q, core_twrite_d;
  logic [31:0] core_taddr_q, core_taddr_d;
  logic [31:0] core_twdata_q, core_twdata_d;
  logic [1:0] tidx;

  assign tidx = core_tack[2] ? 2'h2 : (core_tack[1] ? 2'h1 : 2'h0);

  // I/O-space cycles and missing functions are never claimed
  always_comb
  begin
    tgt_claim_d = 1'h0;
    tgt_reject_d = 1'h0;
    tgt_done_d = 1'h0;
    tgt_rdata_d = tgt_rdata_q;
    core_tsel_d = 3'h0;
    core_twrite_d = core_twrite_q;
    core_taddr_d = core_taddr_q;
    core_twdata_d = core_twdata_q;
    if (tgt_valid)
    begin
      if (tgt_space == TGT_SPACE_MEM && tgt_func <= TGT_FUNC_LAST)
      begin
        tgt_claim_d = 1'h1;
        core_tsel_d = 3'h1 << tgt_func;
        core_twrite_d = tgt_write;
        core_taddr_d = tgt_addr;
        core_twdata_d = tgt_wdata;
      end
      else
        tgt_reject_d = 1'h1;
    end
    if (|core_tack)
    begin
      tgt_done_d = 1'h1;
      tgt_rdata_d = core_trdata[tidx * DATA_W +: DATA_W];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tgt_claim_q <= 1'h0;
      tgt_reject_q <= 1'h0;
      tgt_done_q <= 1'h0;
      tgt_rdata_q <= 32'h0;
      core_tsel_q <= 3'h0;
      core_twrite_q <= 1'h0;
      core_taddr_q <= 32'h0;
      core_twdata_q <= 32'h0;
    end
    else
    begin
      tgt_claim_q <= tgt_claim_d;
      tgt_reject_q <= tgt_reject_d;
      tgt_done_q <= tgt_done_d;
      tgt_rdata_q <= tgt_rdata_d;
      core_tsel_q <= core_tsel_d;
      core_twrite_q <= core_twrite_d;
      core_taddr_q <= core_taddr_d;
      core_twdata_q <= core_twdata_d;
    end
  end

  // ---------------- Root hub routing ----------------
  owner_t owner_q [NUM_PORTS];
  owner_t owner_d [NUM_PORTS];
  logic [4:0] phy_tx_en_q, phy_tx_en_d;
  logic [39:0] phy_tx_data_q, phy_tx_data_d;
  logic [14:0] core_rx_valid_q, core_rx_valid_d;
  logic [39:0] core_rx_data_q, core_rx_data_d;

  // Traffic is gated by the registered owner so a handover never mixes two cores
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    always_comb
    begin
      logic [4:0] own_m;
      own_m = core_mask(owner_q[p]);
      if (p >= int'(port_count_q))
        owner_d[p] = OWN_NONE;
      else if (hs_port_claim[p])
        owner_d[p] = OWN_HS;
      else
        owner_d[p] = companion(p);
      phy_tx_en_d[p] = 1'h0;
      phy_tx_data_d[p * LANE_W +: LANE_W] = 8'h00;
      for (int c = 0; c < NUM_CORES; c++)
      begin
        core_rx_valid_d[c * NUM_PORTS + p] = 1'h0;
        if (owner_q[p] == owner_t'(c + 1) && own_m[p])
        begin
          phy_tx_en_d[p] = core_tx_en[c * NUM_PORTS + p];
          phy_tx_data_d[p * LANE_W +: LANE_W] =
            core_tx_data[(c * NUM_PORTS + p) * LANE_W +: LANE_W];
          core_rx_valid_d[c * NUM_PORTS + p] = phy_rx_valid[p];
        end
      end
      core_rx_data_d[p * LANE_W +: LANE_W] = phy_rx_data[p * LANE_W +: LANE_W];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        owner_q[p] <= OWN_NONE;
      else
        owner_q[p] <= owner_d[p];
    end

    assign port_owner[p * 2 +: 2] = owner_q[p];
    assign port_enabled[p] = (owner_q[p] != OWN_NONE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phy_tx_en_q <= 5'h00;
      phy_tx_data_q <= 40'h0;
      core_rx_valid_q <= 15'h0;
      core_rx_data_q <= 40'h0;
    end
    else
    begin
      phy_tx_en_q <= phy_tx_en_d;
      phy_tx_data_q <= phy_tx_data_d;
      core_rx_valid_q <= core_rx_valid_d;
      core_rx_data_q <= core_rx_data_d;
    end
  end

  // ---------------- Interrupt merge ----------------
  logic [2:0] int_oe_q, int_oe_d;
  logic smi_n_q, smi_n_d;
  logic pme_q, pme_d;

  // Sharing mode keeps the second and third lines released
  // The setting is used unregistered so it lines up with the requests it steers
  always_comb
  begin
    if (irq_share_cfg)
      int_oe_d = {2'h0, |core_irq};
    else
      int_oe_d = {core_irq[CORE_HS], core_irq[CORE_FS2], core_irq[CORE_FS1]};
    smi_n_d = ~(|core_smi);
    pme_d = |core_wake;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_oe_q <= 3'h0;
      smi_n_q <= 1'h1;
      pme_q <= 1'h0;
    end
    else
    begin
      int_oe_q <= int_oe_d;
      smi_n_q <= smi_n_d;
      pme_q <= pme_d;
    end
  end

  // Output wiring
  assign core_mack = core_mack_q;
  assign core_mrdata = core_mrdata_q;
  assign mst_req = mst_req_q;
  assign mst_write = mst_write_q;
  assign mst_addr = mst_addr_q;
  assign mst_wdata = mst_wdata_q;
  assign tgt_claim = tgt_claim_q;
  assign tgt_reject = tgt_reject_q;
  assign tgt_done = tgt_done_q;
  assign tgt_rdata = tgt_rdata_q;
  assign core_tsel = core_tsel_q;
  assign core_twrite = core_twrite_q;
  assign core_taddr = core_taddr_q;
  assign core_twdata = core_twdata_q;
  assign phy_tx_en = phy_tx_en_q;
  assign phy_tx_data = phy_tx_data_q;
  assign core_rx_valid = core_rx_valid_q;
  assign core_rx_data = core_rx_data_q;
  assign int_a_oe = int_oe_q[0];
  assign int_b_oe = int_oe_q[1];
  assign int_c_oe = int_oe_q[2];
  assign sys_mgmt_irq_out_n = smi_n_q;
  assign pme_oe = pme_q;

endmodule

// ===== test/usb_glue_checker.sv
// Port assertions for the bus, routing and interrupt glue
`timescale 1ns/1ps
module usb_glue_checker
  import usb_glue_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_share_cfg,
  input wire logic [2:0] core_irq,
  input wire logic [2:0] core_smi,
  input wire logic [2:0] core_wake,
  input wire logic int_a_oe,
  input wire logic int_b_oe,
  input wire logic int_c_oe,
  input wire logic sys_mgmt_irq_out_n,
  input wire logic pme_oe,
  input wire logic [2:0] core_mack,
  input wire logic mst_req,
  input wire logic mst_done,
  input wire logic tgt_valid,
  input wire logic tgt_space,
  input wire logic [1:0] tgt_func,
  input wire logic tgt_claim,
  input wire logic tgt_reject,
  input wire logic [2:0] core_tsel,
  input wire logic [2:0] core_tack,
  input wire logic tgt_done,
  input wire logic [9:0] port_owner,
  input wire logic [14:0] core_rx_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Interrupt outputs lag their causes by one edge; skip the edge leaving reset
  line_a_a: assert property ($past(rstn) |-> int_a_oe ==
    $past(core_irq[0] | (irq_share_cfg & |core_irq[2:1]))) else $error("line A wrong");
  line_b_a: assert property ($past(rstn) |->
    int_b_oe == $past(core_irq[1] & !irq_share_cfg)) else $error("line B wrong");
  line_c_a: assert property ($past(rstn) |->
    int_c_oe == $past(core_irq[2] & !irq_share_cfg)) else $error("line C wrong");
  mgmt_merge_a: assert property ($past(rstn) |->
    sys_mgmt_irq_out_n == !$past(|core_smi)) else $error("mgmt merge wrong");
  wake_merge_a: assert property ($past(rstn) |->
    pme_oe == $past(|core_wake)) else $error("wake merge wrong");
  // Master engine completion goes back to exactly one core
  ack_onehot_a: assert property ($onehot0(core_mack)) else $error("ack not one-hot");
  done_ack_a: assert property (mst_req && mst_done |=> !mst_req && $onehot(core_mack))
    else $error("completion not passed back");
  tgt_reject_a: assert property (tgt_valid && !(tgt_space == TGT_SPACE_MEM &&
    tgt_func != 2'h3) |=> tgt_reject && !tgt_claim && core_tsel == 3'h0)
    else $error("bad access not refused");
  tgt_claim_a: assert property (tgt_valid && tgt_space == TGT_SPACE_MEM &&
    tgt_func != 2'h3 |=> tgt_claim && core_tsel == 3'h1 << $past(tgt_func))
    else $error("memory access not claimed");
  tgt_done_a: assert property (|core_tack |=> tgt_done) else $error("no target done");
  fs_ports_a: assert property (port_owner[3:2] != OWN_FS1 && port_owner[7:6] != OWN_FS1 &&
    port_owner[1:0] != OWN_FS2 && port_owner[5:4] != OWN_FS2 && port_owner[9:8] != OWN_FS2)
    else $error("companion on wrong port");
  rx_owner_a: assert property ((core_rx_valid & 15'h02AA) == 15'h0000)
    else $error("traffic to foreign core");
  cover property (mst_req && mst_done);
  cover property (tgt_reject);
  cover property (irq_share_cfg && int_a_oe);
endmodule

bind usb_core_port_routing_irq_merge usb_glue_checker chk_u (.clk(clk), .rstn(rstn),
  .irq_share_cfg(irq_share_cfg), .core_irq(core_irq), .core_smi(core_smi),
  .core_wake(core_wake), .int_a_oe(int_a_oe), .int_b_oe(int_b_oe), .int_c_oe(int_c_oe),
  .sys_mgmt_irq_out_n(sys_mgmt_irq_out_n), .pme_oe(pme_oe), .core_mack(core_mack),
  .mst_req(mst_req), .mst_done(mst_done), .tgt_valid(tgt_valid), .tgt_space(tgt_space),
  .tgt_func(tgt_func), .tgt_claim(tgt_claim), .tgt_reject(tgt_reject),
  .core_tsel(core_tsel), .core_tack(core_tack), .tgt_done(tgt_done),
  .port_owner(port_owner), .core_rx_valid(core_rx_valid));

// ===== test/mst_engine_model.sv
// Host bus master engine model answering one word per request
`timescale 1ns/1ps
module mst_engine_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic mst_req,
  input wire logic [31:0] mst_addr,
  output logic mst_done,
  output logic [31:0] mst_rdata
);
  logic [2:0] wait_q;

  // Read data is the inverted address; between answers it churns so stale data shows
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_q <= 3'h0;
      mst_done <= 1'b0;
      mst_rdata <= 32'h0;
    end
    else
    begin
      mst_done <= 1'b0;
      mst_rdata <= mst_rdata + 32'h9E3779B9;
      if (mst_req && !mst_done)
      begin
        if (wait_q >= (slow ? 3'h5 : 3'h0))
        begin
          mst_done <= 1'b1;
          mst_rdata <= ~mst_addr;
          wait_q <= 3'h0;
        end
        else
          wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule

// ===== test/tb_usb_core_port_routing_irq_merge.sv
// Self-checking bench for the routing and interrupt glue
`timescale 1ns/1ps
module tb_usb_core_port_routing_irq_merge;
  import usb_glue_pkg::*;
  logic clk = 0, rstn = 0, slow = 0, irq_share_cfg = 0, mst_done, tgt_valid = 0, tgt_space = 0;
  logic tgt_write = 0, tgt_claim, tgt_reject, tgt_done, core_twrite, mst_req, mst_write;
  logic int_a_oe, int_b_oe, int_c_oe, sys_mgmt_irq_out_n, pme_oe;
  logic [2:0] port_count_cfg = 3'h5, core_mreq = 0, core_mwrite = 0, core_mack, core_tsel;
  logic [2:0] core_tack = 0, core_irq = 0, core_smi = 0, core_wake = 0;
  logic [1:0] tgt_func = 0;
  logic [95:0] core_maddr = 0, core_mwdata = 0, core_trdata = 0;
  logic [31:0] core_mrdata, mst_addr, mst_wdata, mst_rdata, tgt_addr = 0, tgt_wdata = 0;
  logic [31:0] tgt_rdata, core_taddr, core_twdata;
  logic [4:0] hs_port_claim = 0, port_enabled, phy_tx_en, phy_rx_valid = 0;
  logic [9:0] port_owner;
  logic [14:0] core_tx_en = 0, core_rx_valid;
  logic [119:0] core_tx_data = 0;
  logic [39:0] core_rx_data, phy_tx_data, phy_rx_data = 0;
  logic [34:0] exp_q[$];
  int bad_count = 0, compares = 0;

  usb_core_port_routing_irq_merge dut_u (.*);
  mst_engine_model eng_u (.clk(clk), .rstn(rstn), .slow(slow), .mst_req(mst_req),
    .mst_addr(mst_addr), .mst_done(mst_done), .mst_rdata(mst_rdata));

  // One fixed clock source, 40 ns period, for the whole run
  initial forever #20 clk = ~clk;

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected owner: HS when claimed, else the companion wired to that port
  function automatic logic [1:0] own(input int p, input logic [2:0] c, input logic [4:0] hs);
    int n;
    n = c < 3'h2 ? 2 : (c > 3'h5 ? 5 : int'(c));
    if (p >= n) return OWN_NONE;
    if (hs[p]) return OWN_HS;
    return (p % 2 == 0) ? OWN_FS1 : OWN_FS2;
  endfunction

  // Cores drop their request once acked; results are matched in order
  always @(negedge clk)
  begin
    if (|core_mack) core_mreq <= core_mreq & ~core_mack;
    if (rstn && mst_req && mst_done)
      chk(mst_wdata === (mst_addr ^ 32'h5A5A5A5A) && mst_write === mst_addr[0], "mst");
    if (rstn && (|core_mack || tgt_done))
    begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected result");
      else chk({core_mack, |core_mack ? core_mrdata : tgt_rdata} === exp_q.pop_front(),
        "result value or order");
    end
  end

  // Core target side: acks at once with fresh data each cycle
  always @(negedge clk)
  begin : tgt_resp
    logic [95:0] d;
    d = {$urandom, $urandom, $urandom};
    core_trdata <= d;
    core_tack <= core_tsel;
    if (|core_tsel) exp_q.push_back({3'h0, d[32 * (core_tsel[2] ? 2 : core_tsel[1]) +: 32]});
  end

  task automatic master_round();
    @(negedge clk);
    core_maddr = {$urandom, $urandom, $urandom};
    for (int c = 0; c < 3; c++)
    begin
      core_mwdata[32 * c +: 32] = core_maddr[32 * c +: 32] ^ 32'h5A5A5A5A;
      core_mwrite[c] = core_maddr[32 * c];
      exp_q.push_back({3'h1 << c, ~core_maddr[32 * c +: 32]});
    end
    core_mreq = 3'h7;
    for (int i = 0; i < 100 && core_mreq != 0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(exp_q.size() == 0, "master results missing");
    $display("master round done");
  endtask

  initial
  begin
    void'($urandom(61592));
    repeat (6) @(negedge clk);
    chk(port_owner === 10'h0 && sys_mgmt_irq_out_n === 1'b1, "reset values");
    rstn = 1;
    master_round();
    slow = 1;
    master_round();
    // Every space and function code, refused ones included
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      {tgt_space, tgt_func} = i[2:0];
      tgt_addr = $urandom;
      tgt_wdata = $urandom;
      tgt_write = i[0];
      tgt_valid = 1;
      @(negedge clk);
      tgt_valid = 0;
      chk(tgt_claim === (i > 3 && i < 7) && tgt_reject === (i < 4 || i == 7), "decode");
      chk(core_tsel === (i > 3 && i < 7 ? 3'h1 << i[1:0] : 3'h0), "select");
      if (i > 3 && i < 7)
      begin
        chk(core_taddr === tgt_addr && core_twdata === tgt_wdata, "target data");
        chk(core_twrite === tgt_write, "target write");
      end
      repeat (3) @(negedge clk);
    end
    $display("target test done");
    for (int i = 0; i < 8; i++)
    begin
      port_count_cfg = i[2:0];
      {hs_port_claim, phy_rx_valid, core_tx_en} = 25'($urandom);
      core_tx_data = 120'({$urandom, $urandom, $urandom, $urandom});
      phy_rx_data = 40'({$urandom, $urandom});
      repeat (3) @(negedge clk);
      for (int p = 0; p < 5; p++)
      begin : port_chk
        logic [1:0] o;
        int c;
        o = own(p, port_count_cfg, hs_port_claim);
        c = int'(o) - 1;
        chk(port_owner[2 * p +: 2] === o && port_enabled[p] === (o != 0), "owner");
        chk(phy_tx_en[p] === (o != 0 && core_tx_en[c * 5 + p]), "tx enable");
        if (phy_tx_en[p])
          chk(phy_tx_data[8 * p +: 8] === core_tx_data[(c * 5 + p) * 8 +: 8], "tx");
        for (int k = 0; k < 3; k++)
          chk(core_rx_valid[k * 5 + p] === (c == k && phy_rx_valid[p]), "rx");
        if (o != 0 && phy_rx_valid[p])
          chk(core_rx_data[8 * p +: 8] === phy_rx_data[8 * p +: 8], "rx data");
      end
    end
    $display("routing test done");
    for (int i = 0; i < 16; i++)
    begin
      {irq_share_cfg, core_irq, core_smi, core_wake} = 10'($urandom);
      @(negedge clk);
      @(negedge clk);
      chk(int_a_oe === (core_irq[0] | irq_share_cfg & |core_irq[2:1]), "line A");
      chk({int_b_oe, int_c_oe} === (irq_share_cfg ? 2'b00 : {core_irq[1], core_irq[2]}), "B C");
      chk(sys_mgmt_irq_out_n === !(|core_smi) && pme_oe === |core_wake, "merge");
    end
    $display("interrupt test done");
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    bad_count++;
    test_done();
  end
endmodule
